// ---- rtl/adc_result_pkg.sv ----
package adc_result_pkg;
    // Register byte addresses on the bus
    localparam logic [11:0] CTRL_A_OFF = 12'h000;
    localparam logic [11:0] CTRL_B_OFF = 12'h004;
    localparam logic [11:0] RES_HIGH_OFF = 12'h008;
    localparam logic [11:0] RES_LOW_OFF = 12'h00C;
    localparam logic [11:0] STATUS_OFF = 12'h010;
    // Field positions
    localparam int CONV_ON_BIT = 0;
    localparam int START_BIT = 1;
    localparam int CHAN_LSB = 2;
    localparam int CHAN_W = 5;
    localparam int JUSTIFY_BIT = 7;
    localparam int BUSY_BIT = 0;
    localparam int ACQ_OK_BIT = 1;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Timing: acquisition and conversion
    localparam int CLK_HZ = 10_000_000;
    localparam int ACQ_NS = 4970;
    localparam int ACQ_CYC = (ACQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CONV_CYC = 11;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_LOAD = 3'b100
    } conv_state_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic ready;
    } apb_resp_t;

    typedef struct packed {
        conv_state_t st;
        logic converter_on;
        logic result_justify_select;
        logic [4:0] channel_select;
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
        logic [9:0] acq_cnt;
        logic [3:0] conv_cnt;
        logic busy;
        apb_resp_t resp;
        logic slverr;
        logic [9:0] sample;
    } state_t;
endpackage : adc_result_pkg

// ---- rtl/adc_result_formatter.sv ----
`timescale 1ns/10ps
`default_nettype none
// Block top: all logic sits in the core below
module adc_result_formatter #(
    parameter int ACQ_CYCLES = adc_result_pkg::ACQ_CYC,
    parameter int CONV_CYCLES = adc_result_pkg::CONV_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [9:0] sample_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic busy_o,
    output logic hold_discharge_o
);
    // Straight pass-through, so every output but the tied-low hold_discharge_o and prdata_o[31:8] stays a flop of the core
    adc_result_core #(
        .ACQ_CYCLES(ACQ_CYCLES),
        .CONV_CYCLES(CONV_CYCLES)
    ) u_adc_result_core (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .sample_i(sample_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .busy_o(busy_o),
        .hold_discharge_o(hold_discharge_o)
    );
endmodule : adc_result_formatter
`default_nettype wire

// ---- rtl/adc_result_core.sv ----
// Operation
// - Left format: result 9:2 to high byte
// - Left format: result 1:0 to low 7:6
// - Right format: result 9:8 to high 1:0
// - Right format: result 7:0 to low byte
// - Result bytes software writable, kept across resets
// - Hold capacitor never discharged between conversions
// - Unused result bits loaded as zero
`timescale 1ns/10ps
`default_nettype none
module adc_result_core #(
    parameter int ACQ_CYCLES = adc_result_pkg::ACQ_CYC,
    parameter int CONV_CYCLES = adc_result_pkg::CONV_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [9:0] sample_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic busy_o,
    output logic hold_discharge_o
);
    adc_result_pkg::state_t s_r;
    adc_result_pkg::state_t s_nxt;
    // Result bytes live outside the reset struct so no reset touches them
    logic [7:0] res_hi_r;
    logic [7:0] res_lo_r;
    logic [7:0] res_hi_nxt;
    logic [7:0] res_lo_nxt;
    logic [9:0] samp_s1_r;
    logic [9:0] samp_s2_r;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] rd_val;
    logic hit;

    // Format a 10-bit result into high and low bytes
    function automatic logic [15:0] fmt(input logic right, input logic [9:0] v);
        if (right) begin
            fmt = {6'h00, v[9:8], v[7:0]};
        end else begin
            fmt = {v[9:2], v[1:0], 6'h00};
        end
    endfunction : fmt

    assign wr_acc = psel_i && penable_i && pwrite_i && !s_r.resp.ready;
    assign rd_acc = psel_i && penable_i && !pwrite_i && !s_r.resp.ready;

    // Read decode, zero above the byte
    always_comb begin
        rd_val = 8'h00;
        hit = 1'b1;
        unique case (paddr_i)
            adc_result_pkg::CTRL_A_OFF: begin
                rd_val = {1'b0, s_r.channel_select, s_r.busy, s_r.converter_on};
            end
            adc_result_pkg::CTRL_B_OFF: begin
                rd_val = {s_r.result_justify_select, 7'h00};
            end
            adc_result_pkg::RES_HIGH_OFF: begin
                rd_val = res_hi_r;
            end
            adc_result_pkg::RES_LOW_OFF: begin
                rd_val = res_lo_r;
            end
            adc_result_pkg::STATUS_OFF: begin
                rd_val = {6'h00, s_r.acq_cnt == 10'h000, s_r.busy};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Next state: bus slave, conversion sequencer
    always_comb begin
        s_nxt = s_r;
        res_hi_nxt = res_hi_r;
        res_lo_nxt = res_lo_r;
        s_nxt.resp.ready = 1'b0;
        s_nxt.slverr = 1'b0;
        if (psel_i && penable_i && !s_r.resp.ready) begin
            // One wait state: answer on the second access edge
            s_nxt.resp.ready = 1'b1;
            s_nxt.slverr = !hit;
            s_nxt.resp.rdata = rd_val;
        end
        if (s_r.acq_cnt != 10'h000) begin
            s_nxt.acq_cnt = s_r.acq_cnt - 10'h001;
        end
        if (wr_acc) begin
            unique case (paddr_i)
                adc_result_pkg::CTRL_A_OFF: begin
                    s_nxt.converter_on = pwdata_i[adc_result_pkg::CONV_ON_BIT];
                    s_nxt.channel_select =
                        pwdata_i[adc_result_pkg::CHAN_LSB +: adc_result_pkg::CHAN_W];
                    // Channel change restarts the acquisition timer, status only
                    if (pwdata_i[adc_result_pkg::CHAN_LSB +: adc_result_pkg::CHAN_W]
                        != s_r.channel_select) begin
                        s_nxt.acq_cnt = 10'(ACQ_CYCLES);
                    end
                    if (pwdata_i[adc_result_pkg::START_BIT] && s_r.converter_on
                        && !s_r.busy) begin
                        s_nxt.busy = 1'b1;
                        s_nxt.st = adc_result_pkg::ST_CONV;
                        s_nxt.conv_cnt = 4'(CONV_CYCLES);
                        s_nxt.sample = samp_s2_r;
                    end
                end
                adc_result_pkg::CTRL_B_OFF: begin
                    s_nxt.result_justify_select = pwdata_i[adc_result_pkg::JUSTIFY_BIT];
                end
                adc_result_pkg::RES_HIGH_OFF: begin
                    res_hi_nxt = pwdata_i[7:0];
                end
                adc_result_pkg::RES_LOW_OFF: begin
                    res_lo_nxt = pwdata_i[7:0];
                end
                default: begin
                end
            endcase
        end
        unique case (s_r.st)
            adc_result_pkg::ST_IDLE: begin
            end
            adc_result_pkg::ST_CONV: begin
                s_nxt.conv_cnt = s_r.conv_cnt - 4'h1;
                if (s_r.conv_cnt == 4'h1) begin
                    s_nxt.st = adc_result_pkg::ST_LOAD;
                end
            end
            adc_result_pkg::ST_LOAD: begin
                // Both bytes in one edge; conversion beats a software write
                {res_hi_nxt, res_lo_nxt} =
                    fmt(s_r.result_justify_select, s_r.sample);
                s_nxt.busy = 1'b0;
                s_nxt.st = adc_result_pkg::ST_IDLE;
            end
            default: begin
                s_nxt.st = adc_result_pkg::ST_IDLE;
            end
        endcase
    end

    // Control state with reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.st <= adc_result_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Results and sample sync, never reset
    always_ff @(posedge clk_i) begin
        res_hi_r <= res_hi_nxt;
        res_lo_r <= res_lo_nxt;
        samp_s1_r <= sample_i;
        samp_s2_r <= samp_s1_r;
    end

    assign prdata_o = {24'h000000, s_r.resp.rdata};
    assign pready_o = s_r.resp.ready;
    assign pslverr_o = s_r.slverr;
    assign busy_o = s_r.busy;
    assign hold_discharge_o = 1'b0;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    load_both_a: assert property (s_r.st == adc_result_pkg::ST_LOAD |=>
        {res_hi_r, res_lo_r} == fmt($past(s_r.result_justify_select), $past(s_r.sample)))
        else $error("result bytes not loaded together");
    left_high_a: assert property (s_r.st == adc_result_pkg::ST_LOAD
        && !s_r.result_justify_select |=> res_hi_r == $past(s_r.sample[9:2]))
        else $error("left high byte wrong");
    left_low_a: assert property (s_r.st == adc_result_pkg::ST_LOAD
        && !s_r.result_justify_select |=> res_lo_r[7:6] == $past(s_r.sample[1:0]))
        else $error("left low bits wrong");
    right_high_a: assert property (s_r.st == adc_result_pkg::ST_LOAD
        && s_r.result_justify_select |=> res_hi_r[1:0] == $past(s_r.sample[9:8]))
        else $error("right high bits wrong");
    right_low_a: assert property (s_r.st == adc_result_pkg::ST_LOAD
        && s_r.result_justify_select |=> res_lo_r == $past(s_r.sample[7:0]))
        else $error("right low byte wrong");
    // Pad side follows the format in force at the load edge
    pad_zero_a: assert property (s_r.st == adc_result_pkg::ST_LOAD |=>
        ($past(s_r.result_justify_select) ? (res_hi_r[7:2] == 6'h00)
        : (res_lo_r[5:0] == 6'h00)))
        else $error("unused result bits not zero");
    sw_write_a: assert property (wr_acc && paddr_i == adc_result_pkg::RES_HIGH_OFF
        && s_r.st != adc_result_pkg::ST_LOAD |=> res_hi_r == $past(pwdata_i[7:0]))
        else $error("high byte write lost");
    no_discharge_a: assert property (busy_o |-> !hold_discharge_o)
        else $error("hold capacitor discharged");
    acq_reload_a: assert property (wr_acc && paddr_i == adc_result_pkg::CTRL_A_OFF
        && pwdata_i[6:2] != s_r.channel_select |=> s_r.acq_cnt != 10'h000)
        else $error("acquisition timer not restarted");
    conv_bound_a: assert property ($rose(busy_o) |-> ##[1:20] !busy_o)
        else $error("conversion did not finish");
    cover_left_c: cover property (s_r.st == adc_result_pkg::ST_LOAD && !s_r.result_justify_select);
    cover_right_c: cover property (s_r.st == adc_result_pkg::ST_LOAD && s_r.result_justify_select);
    cover_err_c: cover property (pslverr_o);
endmodule : adc_result_core
`default_nettype wire

// ---- verif/adc_front_end_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Analog front end: offers a held code to the converter core
module adc_front_end_model (
    input wire logic clk_i,
    input wire logic load_i,
    input wire logic [9:0] code_i,
    output logic [9:0] sample_o
);
    // New code only on request, so it stands still through a conversion
    always_ff @(posedge clk_i) begin
        if (load_i) begin
            sample_o <= code_i;
        end
    end
endmodule : adc_front_end_model
`default_nettype wire

// ---- verif/adc_result_core_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_result_formatter_tb_top;
    localparam int ACQ_N = 6;
    localparam int CONV_N = 4;
    localparam logic [9:0] CORNERS [4] = '{10'h000, 10'h3FF, 10'h2AA, 10'h155};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic load = 1'b1;
    logic [9:0] code = 10'h000;
    wire logic [9:0] sample;
    wire logic [31:0] prdata_o;
    wire logic pready_o;
    wire logic pslverr_o;
    wire logic busy_o;
    wire logic hold_discharge_o;
    int error_cnt = 0;
    int num_checks = 0;
    integer seed = 32'h39299AE5;
    logic [31:0] rd;
    logic err;
    logic [15:0] exp;
    logic [9:0] c;
    logic [4:0] ch;
    int n;

    // Short counts keep the run brief
    adc_result_formatter #(.ACQ_CYCLES(ACQ_N), .CONV_CYCLES(CONV_N)) u_adc_result_formatter (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .sample_i(sample),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o),
        .hold_discharge_o(hold_discharge_o));
    adc_front_end_model u_adc_front_end_model (
        .clk_i(clk_i), .load_i(load), .code_i(code), .sample_o(sample));

    // Clock, 100 ns period
    always #50 clk_i = ~clk_i;

    // Expected {high, low}: right puts zeros on top, left zeros at the bottom
    function automatic logic [15:0] fmt(input logic [9:0] v, input logic right);
        fmt = right ? {6'h00, v} : {v, 6'h00};
    endfunction : fmt

    task chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : chk

    // APB transfer; pready read before this edge's updates land
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    // One conversion of code v; bytes preset to ones to expose unzeroed bits
    task convert(input logic [9:0] v, input logic right);
        code <= v;
        apb(1'b1, adc_result_pkg::RES_HIGH_OFF, 32'h000000FF);
        apb(1'b1, adc_result_pkg::RES_LOW_OFF, 32'h000000FF);
        apb(1'b0, adc_result_pkg::RES_HIGH_OFF, 32'h0);
        chk(rd, 32'h000000FF);
        chk({31'h0, err}, 32'h0);
        apb(1'b1, adc_result_pkg::CTRL_B_OFF, {24'h0, right, 7'h00});
        ch = 5'($random(seed));
        apb(1'b1, adc_result_pkg::CTRL_A_OFF, {25'h0, ch, 2'b01});
        repeat (ACQ_N + 2) @(posedge clk_i);
        // Acquisition reported elapsed, converter idle
        apb(1'b0, adc_result_pkg::STATUS_OFF, 32'h0);
        chk(rd, 32'h00000002);
        apb(1'b1, adc_result_pkg::CTRL_A_OFF, {25'h0, ch, 2'b11});
        chk({31'h0, busy_o}, 32'h1);
        // Busy spans the conversion count plus the load edge
        n = 0;
        while (n < 60 && busy_o === 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        chk(n, CONV_N + 1);
        exp = fmt(v, right);
        apb(1'b0, adc_result_pkg::RES_HIGH_OFF, 32'h0);
        chk(rd, {24'h0, exp[15:8]});
        apb(1'b0, adc_result_pkg::RES_LOW_OFF, 32'h0);
        chk(rd, {24'h0, exp[7:0]});
        chk({31'h0, hold_discharge_o}, 32'h0);
    endtask : convert

    task final_report;
        $display("Checks: %0d, errors: %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    // Main sequence: corner codes first, then random codes, both formats
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            c = (i < 4) ? CORNERS[i] : 10'($random(seed));
            convert(c, i[0]);
        end
        // Start with converter off must leave the result alone
        // A new code would show if a conversion ran anyway
        code <= ~c;
        apb(1'b1, adc_result_pkg::CTRL_A_OFF, 32'h00000000);
        apb(1'b1, adc_result_pkg::CTRL_A_OFF, 32'h00000002);
        chk({31'h0, busy_o}, 32'h0);
        repeat (CONV_N + 4) @(posedge clk_i);
        apb(1'b0, adc_result_pkg::RES_HIGH_OFF, 32'h0);
        chk(rd, {24'h0, exp[15:8]});
        // Unmapped address refused
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // Low result byte survives a mid-run reset
        apb(1'b1, adc_result_pkg::RES_LOW_OFF, 32'h0000005A);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(1'b0, adc_result_pkg::RES_LOW_OFF, 32'h0);
        chk(rd, 32'h0000005A);
        final_report();
    end

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        final_report();
    end
endmodule : adc_result_formatter_tb_top
`default_nettype wire
